/* logic/sasc_pkg.sv */
// package for the station-address setup command executor
// assumes a 32-bit shared memory port and a single device clock
package sasc_pkg;
  localparam int CMD_WORD_W = 32;
  localparam int OPCODE_LSB = 16;
  localparam int OPCODE_MSB = 18;
  localparam logic [2:0] OPCODE_ADDR_SETUP = 3'h1;
  localparam int BIT_LIST_END = 31;
  localparam int BIT_DONE = 15;
  localparam int BIT_BUSY = 14;
  localparam int BIT_NO_ERROR = 13;
  localparam int BIT_ABORTED = 12;
  localparam int ADDR_MAX_BYTES = 6;
  localparam logic [2:0] ADDR_LEN_DEFAULT = 3'h6;
  localparam logic [47:0] BROADCAST_ADDR = 48'hffff_ffff_ffff;
  localparam logic [31:0] OFS_LINK_WORD = 32'h0000_0004;
  localparam logic [31:0] OFS_ADDR_WORD = 32'h0000_0008;
endpackage : sasc_pkg

/* logic/sasc_addr_compare.sv */
// receive destination matcher against the current station address
// assumes the destination field is presented byte 0 in bits 7:0
`timescale 1ns/100ps
module sasc_addr_compare (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [47:0] stationAddress,
  input wire logic [2:0] addrLen,
  input wire logic [47:0] rxDestAddr,
  input wire logic rxDestValid,
  output logic rxMatch_reg
);
  logic [5:0] byteEq;

  // per-byte compare; bytes beyond the length always agree
  for (genvar i = 0; i < 6; i++) begin : g_byte
    assign byteEq[i] = (i >= addrLen) || (rxDestAddr[8*i +: 8] == stationAddress[8*i +: 8]);
  end

  // registered so that the result comes straight from a flip-flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxMatch_reg <= 1'b0;
    end else begin
      rxMatch_reg <= rxDestValid && (&byteEq); // [R1] [R2]
    end
  end
endmodule : sasc_addr_compare

/* logic/sasc_cmd_exec.sv */
// station-address setup command executor of the command unit
// assumes a one-request memory port answering with memAck, 32-bit words
`timescale 1ns/100ps
// Summary of operation
// (R1) keep loaded address; source on transmit, destination match on receive
// (R2) broadcast address is the station address from reset until first setup
// (R3) broadcast also used as transmit source then, only when inline mode is off
// (R4) opcode bits 16 to 18 equal to 1 selects address setup
// (R5) host writes zeros into command bits 19 to 28 in 32-bit modes
// (R6) aborted bit set when a command-unit abort cut the command short
// (R7) address length zero to six bytes, that many bytes read
// (R8) least significant address bit is neither checked nor forced
// (R9) host should configure length before setup when not six bytes
// (R10) busy bit set at start or prefetch, cleared when done
// (R11) done and busy bits written together in one memory write
// (R12) no-error bit written one when no error, zero otherwise
// (R13) segmented: first byte upper half of link word; linear: after link word
// (R14) follow link to next block unless the list end flag is set
module sasc_cmd_exec (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmdStart,
  input wire logic [31:0] cmdBase,
  input wire logic linearMode,
  input wire logic headerInlineMode,
  input wire logic [2:0] addrLenCfg,
  input wire logic abortReq,
  output logic memReq_reg,
  output logic memWrite_reg,
  output logic [31:0] memAddr_reg,
  output logic [31:0] memWdata_reg,
  input wire logic [31:0] memRdata,
  input wire logic memAck,
  output logic cmdDone_reg,
  output logic cmdUnknown_reg,
  output logic nextValid_reg,
  output logic [31:0] nextBase_reg,
  output logic [47:0] stationAddress_reg,
  output logic [47:0] txSourceAddr_reg,
  output logic txSourceValid_reg,
  input wire logic [47:0] rxDestAddr,
  input wire logic rxDestValid,
  output logic rxMatch_reg
);
  typedef enum {S_IDLE, S_RD_CMD, S_WR_BUSY, S_RD_LINK, S_RD_ADDR, S_WR_DONE} sasc_state_e;
  sasc_state_e state_reg;
  logic [31:0] cmdWord_reg;
  logic [31:0] linkWord_reg;
  logic [47:0] addrShadow_reg;
  logic [2:0] byteCnt_reg;
  logic aborted_reg;
  logic loaded_reg;
  logic [2:0] addrLen;
  logic isSetup;

  // lengths above six are clipped, the command block holds at most six
  assign addrLen = (addrLenCfg > 3'(sasc_pkg::ADDR_MAX_BYTES)) ?
    3'(sasc_pkg::ADDR_MAX_BYTES) : addrLenCfg; // [R7]
  assign isSetup = memRdata[sasc_pkg::OPCODE_MSB:sasc_pkg::OPCODE_LSB] ==
    sasc_pkg::OPCODE_ADDR_SETUP; // [R4]

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: read command, mark busy, read address, write status
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      memReq_reg <= 1'b0;
      memWrite_reg <= 1'b0;
      memAddr_reg <= 32'h0;
      memWdata_reg <= 32'h0;
      cmdWord_reg <= 32'h0;
      linkWord_reg <= 32'h0;
      byteCnt_reg <= 3'h0;
      aborted_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (cmdStart) begin
            state_reg <= S_RD_CMD;
            memReq_reg <= 1'b1;
            memWrite_reg <= 1'b0;
            memAddr_reg <= cmdBase;
            aborted_reg <= 1'b0;
          end
        end
        S_RD_CMD: begin
          if (memAck) begin
            cmdWord_reg <= memRdata;
            if (isSetup) begin
              // bits 19..28 are not inspected; the host keeps them zero [R5]
              state_reg <= S_WR_BUSY;
              memWrite_reg <= 1'b1;
              memAddr_reg <= cmdBase;
              memWdata_reg <= memRdata | (32'h1 << sasc_pkg::BIT_BUSY); // [R10]
            end else begin
              state_reg <= S_IDLE;
              memReq_reg <= 1'b0;
            end
          end
        end
        S_WR_BUSY: begin
          if (memAck) begin
            state_reg <= S_RD_LINK;
            memWrite_reg <= 1'b0;
            memAddr_reg <= cmdBase + sasc_pkg::OFS_LINK_WORD;
          end
        end
        S_RD_LINK: begin
          if (memAck) begin
            linkWord_reg <= memRdata;
            if (!linearMode) begin
              // segmented: first address byte shares the link word [R13]
              byteCnt_reg <= (addrLen != 3'h0) ? 3'h1 : 3'h0;
            end else begin
              byteCnt_reg <= 3'h0;
            end
            memAddr_reg <= cmdBase + sasc_pkg::OFS_ADDR_WORD;
            if (abortReq) begin
              state_reg <= S_WR_DONE;
              aborted_reg <= 1'b1;
            end else if ((!linearMode && addrLen <= 3'h1) || addrLen == 3'h0) begin
              state_reg <= S_WR_DONE;
            end else begin
              state_reg <= S_RD_ADDR;
            end
            if (abortReq || (!linearMode && addrLen <= 3'h1) || addrLen == 3'h0) begin
              memWrite_reg <= 1'b1;
              memAddr_reg <= cmdBase;
            end
          end
        end
        S_RD_ADDR: begin
          if (memAck) begin
            // four bytes a word, lowest lane first [R7] [R13]
            if (abortReq || 3'(byteCnt_reg + 3'h4) >= addrLen || byteCnt_reg > 3'h2) begin
              state_reg <= S_WR_DONE;
              memWrite_reg <= 1'b1;
              memAddr_reg <= cmdBase;
              aborted_reg <= abortReq; // [R6]
            end else begin
              memAddr_reg <= memAddr_reg + 32'h4;
            end
            byteCnt_reg <= 3'(byteCnt_reg + 3'h4);
          end
        end
        S_WR_DONE: begin
          // done and busy change in the same single write [R11]
          memWdata_reg <= (cmdWord_reg & ~(32'h1 << sasc_pkg::BIT_BUSY))
            | (32'h1 << sasc_pkg::BIT_DONE)
            | ({31'h0, ~aborted_reg} << sasc_pkg::BIT_NO_ERROR) // [R12]
            | ({31'h0, aborted_reg} << sasc_pkg::BIT_ABORTED); // [R6]
          if (memAck) begin
            state_reg <= S_IDLE;
            memReq_reg <= 1'b0;
            memWrite_reg <= 1'b0;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address byte gathering; lsb kept as given [R8]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addrShadow_reg <= 48'h0;
    end else if (state_reg == S_RD_LINK && memAck) begin
      addrShadow_reg <= linearMode ? 48'h0 : {40'h0, memRdata[31:24]}; // [R13]
    end else if (state_reg == S_RD_ADDR && memAck) begin
      for (int b = 0; b < 4; b++) begin
        if (32'(byteCnt_reg) + b < 32'(addrLen)) begin
          addrShadow_reg[8*(32'(byteCnt_reg) + b) +: 8] <= memRdata[8*b +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // station address: broadcast until the first clean load [R2]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stationAddress_reg <= sasc_pkg::BROADCAST_ADDR; // [R2]
      loaded_reg <= 1'b0;
    end else if (state_reg == S_WR_DONE && memAck && !aborted_reg) begin
      stationAddress_reg <= addrShadow_reg; // [R1]
      loaded_reg <= 1'b1;
    end
  end

  // transmit source; before any load it is offered only in non-inline mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txSourceAddr_reg <= sasc_pkg::BROADCAST_ADDR;
      txSourceValid_reg <= 1'b0;
    end else begin
      txSourceAddr_reg <= stationAddress_reg; // [R1]
      txSourceValid_reg <= loaded_reg || !headerInlineMode; // [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion pulse and link to the next block [R14]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmdDone_reg <= 1'b0;
      cmdUnknown_reg <= 1'b0;
      nextValid_reg <= 1'b0;
      nextBase_reg <= 32'h0;
    end else begin
      cmdDone_reg <= state_reg == S_WR_DONE && memAck;
      cmdUnknown_reg <= state_reg == S_RD_CMD && memAck && !isSetup;
      nextValid_reg <= state_reg == S_WR_DONE && memAck && !cmdWord_reg[sasc_pkg::BIT_LIST_END];
      if (state_reg == S_WR_DONE && memAck) begin
        nextBase_reg <= linearMode ? linkWord_reg : {16'h0, linkWord_reg[15:0]}; // [R14]
      end
    end
  end

  sasc_addr_compare u_cmp (
    .clock(clock),
    .rst_n(rst_n),
    .stationAddress(stationAddress_reg),
    .addrLen(addrLen),
    .rxDestAddr(rxDestAddr),
    .rxDestValid(rxDestValid),
    .rxMatch_reg(rxMatch_reg)
  );

  ////////////////////////////////////////////////////////////////////////////
  property p_default_broadcast;
    @(posedge clock) disable iff (!rst_n)
      !loaded_reg |-> stationAddress_reg == sasc_pkg::BROADCAST_ADDR;
  endproperty
  a_default_broadcast: assert property (p_default_broadcast) else $error("address left broadcast"); // [R2]

  property p_done_single_write;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == S_WR_DONE && memAck) |-> memWrite_reg && memWdata_reg[sasc_pkg::BIT_DONE]
        && !memWdata_reg[sasc_pkg::BIT_BUSY];
  endproperty
  a_done_single_write: assert property (p_done_single_write) else $error("status write wrong"); // [R11]

  property p_busy_write;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == S_WR_BUSY && memAck) |-> memWdata_reg[sasc_pkg::BIT_BUSY];
  endproperty
  a_busy_write: assert property (p_busy_write) else $error("busy bit not written"); // [R10]

  property p_ok_vs_abort;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == S_WR_DONE && memAck) |->
        memWdata_reg[sasc_pkg::BIT_NO_ERROR] != memWdata_reg[sasc_pkg::BIT_ABORTED];
  endproperty
  a_ok_vs_abort: assert property (p_ok_vs_abort) else $error("ok and abort bits clash"); // [R12]

  property p_load;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == S_WR_DONE && memAck && !aborted_reg) |=> stationAddress_reg == $past(addrShadow_reg);
  endproperty
  a_load: assert property (p_load) else $error("address not loaded"); // [R1]

  property p_tx_src;
    @(posedge clock) disable iff (!rst_n)
      (!loaded_reg && headerInlineMode) |=> !txSourceValid_reg;
  endproperty
  a_tx_src: assert property (p_tx_src) else $error("source offered in inline mode"); // [R3]

  property p_decode;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == S_RD_CMD && memAck && !isSetup) |=> state_reg == S_IDLE && cmdUnknown_reg;
  endproperty
  a_decode: assert property (p_decode) else $error("wrong opcode accepted"); // [R4]

  property p_next;
    @(posedge clock) disable iff (!rst_n)
      nextValid_reg |-> !cmdWord_reg[sasc_pkg::BIT_LIST_END] && cmdDone_reg;
  endproperty
  a_next: assert property (p_next) else $error("link followed past list end"); // [R14]
endmodule : sasc_cmd_exec

/* dv/sasc_mem_model.sv */
// shared memory model of the host side, one access at a time
// assumes the bench preloads mem and reads the write log by hierarchy
`timescale 1ns/100ps
module sasc_mem_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] ackDelay,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  output logic [31:0] memRdata,
  output logic memAck
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] wrAddr [$];
  logic [31:0] wrData [$];
  logic [31:0] lastData;
  logic [3:0] waitCnt;
  // released bus shows the inverse so a late sample reads wrong data
  assign memRdata = memAck ? lastData : ~lastData;
  ////////////////////////////////////////////////////////////////////
  // blocks are laid out by the bench reserved bits zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
      lastData <= 32'h0;
    end else if (memReq && !memAck && waitCnt >= ackDelay) begin
      memAck <= 1'b1;
      waitCnt <= 4'h0;
      if (memWrite) begin
        mem[memAddr] = memWdata;
        wrAddr.push_back(memAddr);
        wrData.push_back(memWdata);
      end else begin
        lastData <= mem.exists(memAddr) ? mem[memAddr] : 32'h0;
      end
    end else begin
      memAck <= 1'b0;
      waitCnt <= (memReq && !memAck) ? waitCnt + 4'h1 : 4'h0;
    end
  end
endmodule : sasc_mem_model

/* dv/test_station_address_setup_cmd.sv */
// self-checking bench for the station-address setup executor
// assumes the memory model answers with an ack delay set per test
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module test_station_address_setup_cmd;
  logic clock = 1'b0, rst_n = 1'b0, cmdStart = 1'b0, linearMode = 1'b1, inl = 1'b0;
  logic abortReq = 1'b0, rxDestValid = 1'b0, memReq, memWrite, memAck, cmdDone, cmdUnk;
  logic nextValid, txValid, rxMatch;
  logic [31:0] cmdBase = 32'h0, memAddr, memWdata, memRdata, nextBase;
  logic [47:0] station, txSrc, rxDestAddr = 48'h0;
  logic [3:0] ackDelay = 4'h1;
  logic [2:0] addrLen = 3'h6;
  int mismatches = 0, total_checks = 0;
  sasc_cmd_exec dut (.clock(clock), .rst_n(rst_n), .cmdStart(cmdStart), .cmdBase(cmdBase),
    .linearMode(linearMode), .headerInlineMode(inl), .addrLenCfg(addrLen), .abortReq(abortReq),
    .memReq_reg(memReq), .memWrite_reg(memWrite), .memAddr_reg(memAddr),
    .memWdata_reg(memWdata), .memRdata(memRdata), .memAck(memAck), .cmdDone_reg(cmdDone),
    .cmdUnknown_reg(cmdUnk), .nextValid_reg(nextValid), .nextBase_reg(nextBase),
    .stationAddress_reg(station), .txSourceAddr_reg(txSrc), .txSourceValid_reg(txValid),
    .rxDestAddr(rxDestAddr), .rxDestValid(rxDestValid), .rxMatch_reg(rxMatch));
  sasc_mem_model mdl (.clock(clock), .rst_n(rst_n), .ackDelay(ackDelay), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .memAck(memAck));
  initial begin
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // one destination compare, result seen one cycle later
  task automatic rxCheck(input logic [47:0] a, input logic e);
    #1 rxDestAddr = a;
    rxDestValid = 1'b1;
    @(posedge clock);
    #1 rxDestValid = 1'b0;
    `CHK(rxMatch, e)
    @(posedge clock);
  endtask : rxCheck
  task automatic resetDut;
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    // look after the edge settles, the source valid flop updates on it
    @(posedge clock) #1;
    `CHK(station, sasc_pkg::BROADCAST_ADDR)
    `CHK(txSrc, sasc_pkg::BROADCAST_ADDR)
    `CHK(txValid, ~inl)
    rxCheck(sasc_pkg::BROADCAST_ADDR, 1'b1);
    $display("test reset done");
  endtask : resetDut
  // load a block, start it, wait bounded for done or unknown
  task automatic runCmd(input logic [31:0] b, w0, w1, w2, w3, output logic nxt);
    int n;
    // keep stimulus off the sampling edge
    #1;
    mdl.mem[b] = w0;
    mdl.mem[b + 4] = w1;
    mdl.mem[b + 8] = w2;
    mdl.mem[b + 12] = w3;
    mdl.wrAddr.delete();
    mdl.wrData.delete();
    cmdBase = b;
    cmdStart = 1'b1;
    @(posedge clock);
    #1 cmdStart = 1'b0;
    for (n = 0; n < 300 && cmdDone !== 1'b1 && cmdUnk !== 1'b1; n++) @(posedge clock) #1;
    if (n == 300) mismatches++;
    nxt = nextValid;
  endtask : runCmd
  // a finished setup: busy then status write, both to the block base
  task automatic setupOk(input logic [31:0] b, w0, w1, w2, w3, input logic [47:0] a,
                         input logic [3:0] st);
    logic nxt;
    runCmd(b, w0, w1, w2, w3, nxt);
    `CHK(mdl.wrData.size(), 2)
    `CHK(mdl.wrData[0][15:14], 2'h1)
    `CHK(mdl.wrAddr[1], b)
    `CHK(mdl.wrData[1][15:12], st)
    `CHK(station, a)
    `CHK(nxt, ~w0[31])
    // past the edge, so the transmit source copy has settled
    @(posedge clock) #1;
  endtask : setupOk
  initial begin
    logic nxt;
    resetDut();
    // odd first byte must be stored as is
    setupOk(32'h100, 32'h0001_0000, 32'h200, 32'h4433_2201, 32'h6655, 48'h6655_4433_2201,
            4'ha);
    `CHK(nextBase, 32'h200)
    `CHK(txSrc, 48'h6655_4433_2201)
    rxCheck(48'h6655_4433_2201, 1'b1);
    rxCheck(sasc_pkg::BROADCAST_ADDR, 1'b0);
    $display("test linear done");
    // slow memory, segmented layout, list end set
    ackDelay = 4'h4;
    linearMode = 1'b0;
    setupOk(32'h300, 32'h8001_0000, 32'h6600_0400, 32'haa99_8877, 32'hbb,
            48'hbbaa_9988_7766, 4'ha);
    $display("test segmented done");
    // abort keeps the old address, then the repeat succeeds
    abortReq = 1'b1;
    setupOk(32'h300, 32'h0001_0000, 32'h6600_0400, 32'h1, 32'h2, 48'hbbaa_9988_7766,
            4'h9);
    abortReq = 1'b0;
    setupOk(32'h300, 32'h0001_0000, 32'h6600_0400, 32'h1, 32'h2, 48'h0200_0000_0166,
            4'ha);
    $display("test abort done");
    // short address: length set before the setup command, only two bytes used
    linearMode = 1'b1;
    addrLen = 3'h2;
    setupOk(32'h600, 32'h0001_0000, 32'h700, 32'h4433_2211, 32'h0, 48'h2211,
            4'ha);
    rxCheck(48'h9999_9999_2211, 1'b1);
    addrLen = 3'h6;
    $display("test length done");
    // another opcode is refused without any memory write
    runCmd(32'h500, 32'h0002_0000, 32'h0, 32'h0, 32'h0, nxt);
    `CHK(cmdUnk, 1'b1)
    `CHK(mdl.wrData.size(), 0)
    $display("test opcode done");
    // inline header mode keeps the transmit source off after reset
    inl = 1'b1;
    resetDut();
    test_done();
  end
  initial begin
    #200us;
    mismatches++;
    test_done();
  end
endmodule : test_station_address_setup_cmd
